// ---- design/gsa_fault_queue.sv ----
// small queue of hardware fault codes
`timescale 1ns/100ps
`include "gsa_params.svh"
module gsa_fault_queue #(
    parameter int DEPTH = `GSA_FAULT_DEPTH,
    parameter int W     = `GSA_FAULT_W
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // queue side
    gsa_fault_if.queue fq
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0]   cnt;
    } gsa_fq_state_t;

    gsa_fq_state_t s_q;
    gsa_fq_state_t s_d;
    logic [W-1:0]  mem_q [DEPTH];

    // pointer bump with wrap
    function automatic logic [AW-1:0] gsa_bump(input logic [AW-1:0] p);
        gsa_bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : gsa_bump

    logic do_push;
    logic do_pop;

    // a push while full is dropped; oldest faults are kept
    assign do_push = fq.push && (s_q.cnt != (AW+1)'(DEPTH));
    assign do_pop  = fq.pop && (s_q.cnt != '0);

    // next pointers and count
    always_comb begin
        s_d = s_q;
        if (do_push) begin
            s_d.wr = gsa_bump(s_q.wr);
        end
        if (do_pop) begin
            s_d.rd = gsa_bump(s_q.rd);
        end
        s_d.cnt = s_q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // storage, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem_q[s_q.wr] <= fq.push_code;
        end
    end

    assign fq.head_code = mem_q[s_q.rd];
    assign fq.not_empty = (s_q.cnt != '0);
    assign fq.full      = (s_q.cnt == (AW+1)'(DEPTH));
endmodule : gsa_fault_queue

// ---- design/gsa_status_addr.sv ----
// status byte, service request and addressing logic of the bus port
// Function
// - poll returns live status while no request
// - poll returns snapshot while request stands
// - polling alone clears no status bit
// - clear commands wipe status unless hardware fault
// - local and ready bits always live
// - sweep end sets, resets on sweep selection
// - hardware fault bit cleared only by read
// - queued fault codes, one per talk address
// - execution fault bit cleared by its read
// - local bit live; local key requests service outside lockout
// - error bit is OR of bits 1,2
// - request bit follows masked status byte
// - parameter changed bit cleared by its read
// - interface clear ends talk and listen
// - trigger ignored, no parallel poll response
// - listen state held until listed events
// - talk state held until listed events
// - lamps for remote, listen, talk, request
// - recall display command honoured in remote
// - masked bits raise request and SRQ
// - mask zero at power on and preset
`timescale 1ns/100ps
`include "gsa_params.svh"
module gsa_status_addr
#(
    parameter int FAULT_DEPTH = `GSA_FAULT_DEPTH,
    parameter int FAULT_W     = `GSA_FAULT_W
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    // instrument conditions and events, one-cycle pulses unless noted
    input  wire logic               sweep_done,
    input  wire logic               sweep_select,
    input  wire logic               hw_fault_evt,
    input  wire logic [FAULT_W-1:0] hw_fault_code,
    input  wire logic               exec_fault_evt,
    input  wire logic               param_chg_evt,
    input  wire logic               ready_lvl,
    input  wire logic               local_key,
    input  wire logic               power_on_evt,
    // decoded commands, one-cycle pulses
    input  wire logic               clear_status_cmd,
    input  wire logic               full_preset_cmd,
    input  wire logic               dev_clear_cmd,
    input  wire logic               read_hw_fault_cmd,
    input  wire logic               read_exec_fault_cmd,
    input  wire logic               read_changed_param_cmd,
    input  wire logic               recall_display_cmd,
    input  wire logic               mask_wr,
    input  wire logic [7:0]         mask_wdata,
    // bus interface messages, one-cycle pulses; remote and lockout are levels
    input  wire logic               remote_lvl,
    input  wire logic               lockout_lvl,
    input  wire logic               ifc_evt,
    input  wire logic               my_listen_addr,
    input  wire logic               my_talk_addr,
    input  wire logic               other_talk_addr,
    input  wire logic               unlisten_cmd,
    input  wire logic               untalk_cmd,
    input  wire logic               trigger_cmd,
    input  wire logic               parallel_poll,
    input  wire logic               serial_poll_rd,
    // poll answer and fault output
    output logic [7:0]              poll_byte,
    output logic                    poll_valid,
    output logic [FAULT_W-1:0]      fault_code_out,
    output logic                    fault_code_valid,
    output logic                    redisplay,
    output logic                    srq_data,
    output logic                    srq_oe_n,
    // front panel lamps
    output logic                    remote_lamp,
    output logic                    listener_lamp,
    output logic                    talker_lamp,
    output logic                    srq_lamp,
    output logic                    front_srq,
    output logic [7:0]              status_byte
);
    import gsa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    // all state in one record; s_d is its next value
    typedef struct packed {
        gsa_events_t        ev;
        logic [7:0]         mask;
        logic [7:0]         snap;
        logic               rqs;
        gsa_addr_t          role;
        logic               hw_reading;
        logic [7:0]         poll_byte;
        logic               poll_valid;
        logic [FAULT_W-1:0] fcode;
        logic               fvalid;
        logic               redisplay;
        logic               srq;
        logic               front_srq;
        logic [7:0]         status;
        logic               srq_n;        // low while SRQ is pulled
        logic               lamp_remote;
        logic               lamp_listen;
        logic               lamp_talk;
    } gsa_state_t;

    gsa_state_t s_q;
    gsa_state_t s_d;

    // a full queue drops new codes; the first fault is the cause
    gsa_fault_if #(.W(FAULT_W)) fq ();

    gsa_fault_queue #(
        .DEPTH (FAULT_DEPTH),
        .W     (FAULT_W)
    ) u_fq (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .fq      (fq)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // assemble the status byte from events, live bits and a request bit
    // bit 5 is derived, never stored, so it cannot drift
    function automatic logic [7:0] gsa_pack(input gsa_events_t e, input logic loc,
                                            input logic rdy, input logic rq);
        logic [7:0] b;
        b = `GSA_STATUS_RESET;
        b[`GSA_BIT_SWEEP_END]  = e.sweep_end;
        b[`GSA_BIT_HW_FAULT]   = e.hw_fault;
        b[`GSA_BIT_EXEC_FAULT] = e.exec_fault;
        b[`GSA_BIT_LOCAL]      = loc;
        b[`GSA_BIT_READY]      = rdy;
        b[`GSA_BIT_ERROR]      = e.hw_fault | e.exec_fault;
        b[`GSA_BIT_RQS]        = rq;
        b[`GSA_BIT_PARAM_CHG]  = e.param_chg;
        gsa_pack = b;
    endfunction : gsa_pack

    // masked request test with bit 6 left out
    // bit 6 is the request itself; letting it in would latch it
    function automatic logic gsa_req(input logic [7:0] b, input logic [7:0] m);
        gsa_req = |(b & m & `GSA_RQS_IGNORE);
    endfunction : gsa_req

    // working values of the next-state process
    logic        any_clear;
    logic        clear_ok;
    logic        local_now;
    logic [7:0]  pre_byte;
    logic [7:0]  live_byte;
    logic        rqs_next;

    // live level; no clear ever touches it
    assign local_now = ~remote_lvl;

    // fault queue hookup: a new fault enters, each talk address after the
    // read command takes one code out
    assign fq.push      = hw_fault_evt;
    assign fq.push_code = hw_fault_code;
    assign fq.pop       = s_q.hw_reading && my_talk_addr && fq.not_empty;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d       = s_q;
        any_clear = clear_status_cmd | full_preset_cmd | dev_clear_cmd | power_on_evt;
        // an unresolved fault blocks the byte-wide clear; a code
        // still waiting in the queue counts as unresolved
        clear_ok  = any_clear && !s_q.ev.hw_fault && !fq.not_empty;

        // sticky events: the reset action first, then the set wins
        // so no event slips past a clear landing with it
        if (clear_ok) begin
            s_d.ev = '0;
        end
        if (sweep_select) begin
            s_d.ev.sweep_end = 1'b0;
        end
        if (sweep_done) begin
            s_d.ev.sweep_end = 1'b1;
        end
        if (read_hw_fault_cmd) begin
            s_d.ev.hw_fault   = 1'b0;
            s_d.hw_reading    = 1'b1;
        end
        if (hw_fault_evt) begin
            s_d.ev.hw_fault = 1'b1;
        end
        if (read_exec_fault_cmd) begin
            s_d.ev.exec_fault = 1'b0;
        end
        if (exec_fault_evt) begin
            s_d.ev.exec_fault = 1'b1;
        end
        if (read_changed_param_cmd) begin
            s_d.ev.param_chg = 1'b0;
        end
        if (param_chg_evt) begin
            s_d.ev.param_chg = 1'b1;
        end

        // request mask: zero on power on and preset
        // preset beats a mask write in the same cycle
        if (mask_wr) begin
            s_d.mask = mask_wdata;
        end
        if (power_on_evt || full_preset_cmd) begin
            s_d.mask = `GSA_MASK_RESET;
        end

        // request bit from the updated events and mask
        // bit 6 forced low so byte and request never loop
        pre_byte = gsa_pack(s_d.ev, local_now, ready_lvl, 1'b0);
        rqs_next = gsa_req(pre_byte, s_d.mask);
        s_d.rqs  = rqs_next;
        live_byte = gsa_pack(s_d.ev, local_now, ready_lvl, rqs_next);
        s_d.status = live_byte;

        // snapshot taken when the request first rises
        if (rqs_next && !s_q.rqs) begin
            s_d.snap = live_byte;
        end

        // serial poll answer; reading clears nothing
        // the snapshot shows what raised the request
        // poll_valid is a strobe; poll_byte holds until the next poll
        s_d.poll_valid = serial_poll_rd;
        if (serial_poll_rd) begin
            if (s_q.rqs) begin
                s_d.poll_byte = s_q.snap;
                s_d.snap      = live_byte;
            end else begin
                s_d.poll_byte = s_q.status;
            end
        end

        // fault code delivery on talk address
        // one code per talk address
        s_d.fvalid = fq.pop;
        if (fq.pop) begin
            s_d.fcode = fq.head_code;
        end
        // reading ends when a talk address finds the queue empty;
        // a new read command in that cycle keeps it going
        if (s_q.hw_reading && my_talk_addr && !fq.not_empty && !read_hw_fault_cmd) begin
            s_d.hw_reading = 1'b0;
        end

        // addressing; trigger and parallel poll have no effect
        // talk wins over listen from idle
        case (s_q.role)
            GSA_IDLE: begin
                if (my_talk_addr) begin
                    s_d.role = GSA_TALK;
                end else if (my_listen_addr) begin
                    s_d.role = GSA_LISTEN;
                end
            end
            GSA_LISTEN: begin
                if (my_talk_addr) begin
                    s_d.role = GSA_TALK;
                end else if (unlisten_cmd) begin
                    s_d.role = GSA_IDLE;
                end
            end
            GSA_TALK: begin
                if (my_listen_addr) begin
                    s_d.role = GSA_LISTEN;
                end else if (other_talk_addr || untalk_cmd) begin
                    s_d.role = GSA_IDLE;
                end
            end
            default: begin
                s_d.role = GSA_IDLE;
            end
        endcase
        if (ifc_evt || power_on_evt) begin
            s_d.role = GSA_IDLE;
        end

        // redisplay only when remote
        // in local the panel keys do this themselves
        s_d.redisplay = recall_display_cmd && remote_lvl;
        // local key outside lockout emulates a panel request
        s_d.front_srq = local_key && !lockout_lvl;

        // SRQ follows the request bit exactly
        s_d.srq   = rqs_next;
        s_d.srq_n = !rqs_next;

        // lamps registered so no panel output comes through a gate
        s_d.lamp_remote = remote_lvl;
        s_d.lamp_listen = (s_d.role == GSA_LISTEN);
        s_d.lamp_talk   = (s_d.role == GSA_TALK);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // one register keeps the reset image in one place

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q             <= '0;
            // SRQ released, remote lamp as for a cleared byte
            s_q.srq_n       <= 1'b1;
            s_q.lamp_remote <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops except srq_data, which is tied low

    assign poll_byte        = s_q.poll_byte;
    assign poll_valid       = s_q.poll_valid;
    assign fault_code_out   = s_q.fcode;
    assign fault_code_valid = s_q.fvalid;
    assign redisplay        = s_q.redisplay;
    // open drain: the data stays low, only the enable moves
    assign srq_data         = 1'b0;
    assign srq_oe_n         = s_q.srq_n;
    assign remote_lamp      = s_q.lamp_remote;
    assign listener_lamp    = s_q.lamp_listen;
    assign talker_lamp      = s_q.lamp_talk;
    assign srq_lamp         = s_q.srq;
    assign front_srq        = s_q.front_srq;
    assign status_byte      = s_q.status;

    // trigger and parallel poll are deliberately left without effect
    logic unused_ok;
    assign unused_ok = trigger_cmd | parallel_poll;
endmodule : gsa_status_addr

// ---- inc/gsa_fault_if.sv ----
// hardware fault queue hookup between the top and the queue
`timescale 1ns/100ps
interface gsa_fault_if #(parameter int W = 8);
    logic         push;
    logic [W-1:0] push_code;
    logic         pop;
    logic [W-1:0] head_code;
    logic         not_empty;
    logic         full;

    modport owner (output push, output push_code, output pop,
                   input head_code, input not_empty, input full);
    modport queue (input push, input push_code, input pop,
                   output head_code, output not_empty, output full);
endinterface : gsa_fault_if

// ---- inc/gsa_params.svh ----
// constants for the bus status and addressing block
`ifndef GSA_PARAMS_SVH
`define GSA_PARAMS_SVH

// status byte bit positions
`define GSA_BIT_SWEEP_END   0
`define GSA_BIT_HW_FAULT    1
`define GSA_BIT_EXEC_FAULT  2
`define GSA_BIT_LOCAL       3
`define GSA_BIT_READY       4
`define GSA_BIT_ERROR       5
`define GSA_BIT_RQS         6
`define GSA_BIT_PARAM_CHG   7

// reset values
`define GSA_MASK_RESET      8'h00
`define GSA_STATUS_RESET    8'h00
// mask bit 6 never takes part in the request decision
`define GSA_RQS_IGNORE      8'hBF

// depth of the hardware fault queue
`define GSA_FAULT_DEPTH     4
`define GSA_FAULT_W         8

`endif

// ---- inc/gsa_pkg.sv ----
// types for the bus status and addressing block
package gsa_pkg;

    // addressing role on the bus
    typedef enum logic [1:0] {
        GSA_IDLE   = 2'b00,
        GSA_LISTEN = 2'b01,
        GSA_TALK   = 2'b10
    } gsa_addr_t;

    // sticky event bits of the status byte
    typedef struct packed {
        logic sweep_end;
        logic hw_fault;
        logic exec_fault;
        logic param_chg;
    } gsa_events_t;

endpackage : gsa_pkg

// ---- verification/gsa_ctrl_model.sv ----
// bus controller model: sends interface messages and collects answers
`timescale 1ns/100ps
module gsa_ctrl_model (
    // clock
    input wire logic       clk_sys,
    // message strobes toward the port
    output logic     [9:0] msg,
    // answers from the port
    input wire logic [7:0] poll_byte,
    input wire logic       poll_valid,
    input wire logic [7:0] fault_code_out,
    input wire logic       fault_code_valid
);
    initial msg = 10'h000;

    // one strobe per message, held over exactly one sampling edge
    task automatic send(input int b);
        @(posedge clk_sys) #1 msg[b] = 1'b1;
        @(posedge clk_sys) #1 msg[b] = 1'b0;
    endtask : send

    // answers stand one cycle; a missing answer reads as unknown
    task automatic poll(output logic [7:0] sb);
        send(8);
        sb = poll_valid ? poll_byte : 8'hXX;
    endtask : poll

    task automatic talk(output logic [7:0] sb);
        send(2);
        sb = fault_code_valid ? fault_code_out : 8'hXX;
    endtask : talk

    // settings are trusted only once a poll shows the ready bit
    task automatic poll_ready(output logic [7:0] sb);
        for (int i = 0; i < 20; i++) begin
            poll(sb);
            if (sb[4] === 1'b1) break;
        end
    endtask : poll_ready
endmodule : gsa_ctrl_model

// ---- verification/gsa_status_addr_properties.sv ----
// concurrent checks on the ports of the status and addressing block
`timescale 1ns/100ps
module gsa_status_addr_properties (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       arst_n,
    // watched inputs
    input wire logic       sweep_done,
    input wire logic       ready_lvl,
    input wire logic       remote_lvl,
    input wire logic       mask_wr,
    input wire logic [7:0] mask_wdata,
    input wire logic       ifc_evt,
    input wire logic       my_talk_addr,
    input wire logic       my_listen_addr,
    input wire logic       serial_poll_rd,
    // watched outputs
    input wire logic [7:0] poll_byte,
    input wire logic       poll_valid,
    input wire logic       fault_code_valid,
    input wire logic       srq_oe_n,
    input wire logic       srq_lamp,
    input wire logic       listener_lamp,
    input wire logic       talker_lamp,
    input wire logic       front_srq,
    input wire logic [7:0] status_byte
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////
    // the open-drain enable is low exactly while the request bit stands
    a_srq_drive: assert property (srq_oe_n == !status_byte[6])
        else $error("srq enable disagrees with request bit");
    a_srq_lamp_on: assert property (srq_lamp == status_byte[6])
        else $error("srq lamp disagrees with request bit");
    a_error_summary: assert property (status_byte[5] == |status_byte[2:1])
        else $error("error bit is not the or of bits 1 and 2");
    // live bits; a level held over two edges must show, whatever clears ran
    a_ready_live: assert property ($past(arst_n) && ready_lvl == $past(ready_lvl)
        |-> status_byte[4] == ready_lvl)
        else $error("ready bit not live");
    a_local_live: assert property ($past(arst_n) && remote_lvl == $past(remote_lvl)
        |-> status_byte[3] == !remote_lvl)
        else $error("local bit not live");
    ////////////////////////////////////////////////////////////////////////////
    // poll answer timing and content, sticky sweep end bit, request bit with empty mask
    a_poll_timing: assert property ($past(arst_n) |-> poll_valid == $past(serial_poll_rd))
        else $error("poll answer not one cycle after poll");
    a_live_poll: assert property (serial_poll_rd && !status_byte[6]
        |=> poll_byte == $past(status_byte))
        else $error("poll without request is not the live byte");
    a_sweep_sticky: assert property (sweep_done |=> status_byte[0])
        else $error("sweep end bit not set");
    a_mask_zero: assert property (mask_wr && mask_wdata == 8'h00 |=> !status_byte[6])
        else $error("request bit stands with empty mask");
    ////////////////////////////////////////////////////////////////////////////
    // addressing roles
    a_ifc_idle: assert property (ifc_evt && !my_talk_addr && !my_listen_addr
        |=> !talker_lamp && !listener_lamp)
        else $error("role held after interface clear");
    a_role_single: assert property (!(talker_lamp && listener_lamp))
        else $error("talker and listener at once");

    c_snap_poll: cover property (serial_poll_rd && status_byte[6]);
    c_fault_pop: cover property (fault_code_valid);
    c_talk: cover property (talker_lamp);
    c_front_srq: cover property (front_srq);
endmodule : gsa_status_addr_properties

bind gsa_status_addr gsa_status_addr_properties gsa_status_addr_properties_inst (.*);

// ---- verification/gsa_status_addr_tb.sv ----
// self-checking bench for the status and addressing block
`timescale 1ns/100ps
module gsa_status_addr_tb;
    logic clk_sys, arst_n = 1'b0;
    logic sweep_done = 0, sweep_select = 0, hw_fault_evt = 0, exec_fault_evt = 0;
    logic param_chg_evt = 0, local_key = 0, power_on_evt = 0, clear_status_cmd = 0;
    logic full_preset_cmd = 0, read_hw_fault_cmd = 0, read_exec_fault_cmd = 0;
    logic read_changed_param_cmd = 0, recall_display_cmd = 0, mask_wr = 0;
    logic ready_lvl = 1, remote_lvl = 1, lockout_lvl = 0;
    logic [7:0] hw_fault_code = 8'h00, mask_wdata = 8'h00, sb;
    logic [9:0] msg;
    logic [7:0] poll_byte, fault_code_out, status_byte;
    logic poll_valid, fault_code_valid, redisplay, srq_data, srq_oe_n, front_srq;
    logic remote_lamp, listener_lamp, talker_lamp, srq_lamp;
    int fail_count = 0, total_checks = 0, cycles = 0;

    gsa_status_addr #(.FAULT_DEPTH(4), .FAULT_W(8)) gsa_status_addr_inst (.*,
        .ifc_evt(msg[0]), .my_listen_addr(msg[1]), .my_talk_addr(msg[2]),
        .other_talk_addr(msg[3]), .unlisten_cmd(msg[4]), .untalk_cmd(msg[5]),
        .trigger_cmd(msg[6]), .parallel_poll(msg[7]), .serial_poll_rd(msg[8]),
        .dev_clear_cmd(msg[9]));
    gsa_ctrl_model gsa_ctrl_model_inst (.*);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // a hang is cut short well past the roughly 125 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic pulse(ref logic s);
        @(posedge clk_sys) #1 s = 1'b1;
        @(posedge clk_sys) #1 s = 1'b0;
    endtask : pulse

    task automatic bus(input int b);
        gsa_ctrl_model_inst.send(b);
    endtask : bus

    task automatic set_mask(input logic [7:0] m);
        mask_wdata = m;
        pulse(mask_wr);
    endtask : set_mask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_poll();
        chk("status", status_byte, 8'h10);
        chk("srq_oe_n", srq_oe_n, 8'h01);
        pulse(sweep_done);
        chk("status", status_byte, 8'h11);
        gsa_ctrl_model_inst.poll(sb);
        chk("poll", sb, 8'h11);
        gsa_ctrl_model_inst.poll(sb);
        chk("poll", sb, 8'h11);
        pulse(sweep_select);
        chk("status", status_byte, 8'h10);
        $display("t_poll done");
    endtask : t_poll

    // snapshot under a standing request, then a fresh byte on the next poll
    task automatic t_snap();
        pulse(sweep_done);
        set_mask(8'h01);
        chk("status", status_byte, 8'h51);
        chk("srq_oe_n", srq_oe_n, 8'h00);
        chk("srq_data", srq_data, 8'h00);
        chk("srq_lamp", srq_lamp, 8'h01);
        gsa_ctrl_model_inst.poll(sb);
        ready_lvl = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("status", status_byte, 8'h41);
        gsa_ctrl_model_inst.poll(sb);
        chk("poll", sb, 8'h51);
        gsa_ctrl_model_inst.poll(sb);
        chk("poll", sb, 8'h41);
        ready_lvl = 1'b1;
        set_mask(8'h00);
        set_mask(8'h40);
        chk("status", status_byte, 8'h11);
        chk("srq_oe_n", srq_oe_n, 8'h01);
        pulse(sweep_select);
        $display("t_snap done");
    endtask : t_snap

    // queued faults block the byte clear and come out one per talk address
    task automatic t_fault();
        hw_fault_code = 8'hA5;
        pulse(hw_fault_evt);
        hw_fault_code = 8'h3C;
        pulse(hw_fault_evt);
        chk("status", status_byte, 8'h32);
        pulse(clear_status_cmd);
        chk("status", status_byte, 8'h32);
        pulse(exec_fault_evt);
        chk("status", status_byte, 8'h36);
        pulse(read_exec_fault_cmd);
        chk("status", status_byte, 8'h32);
        pulse(read_hw_fault_cmd);
        chk("status", status_byte, 8'h10);
        gsa_ctrl_model_inst.talk(sb);
        chk("code", sb, 8'hA5);
        gsa_ctrl_model_inst.talk(sb);
        chk("code", sb, 8'h3C);
        bus(5);
        $display("t_fault done");
    endtask : t_fault

    task automatic t_clear();
        pulse(param_chg_evt);
        chk("status", status_byte, 8'h90);
        pulse(read_changed_param_cmd);
        chk("status", status_byte, 8'h10);
        set_mask(8'h01);
        for (int i = 0; i < 4; i++) begin
            pulse(sweep_done);
            pulse(exec_fault_evt);
            case (i)
                0: pulse(clear_status_cmd);
                1: pulse(full_preset_cmd);
                2: pulse(power_on_evt);
                default: bus(9);
            endcase
            chk("status", status_byte, 8'h10);
        end
        pulse(sweep_done);
        chk("status", status_byte, 8'h11);
        pulse(sweep_select);
        $display("t_clear done");
    endtask : t_clear

    // each message against the {listener, talker} lamps it must leave
    task automatic t_addr();
        int s[15] = '{1, 2, 1, 4, 2, 5, 2, 3, 1, 0, 2, 0, 1, 6, 7};
        logic [1:0] e[15] = '{2, 1, 2, 0, 1, 0, 1, 0, 2, 0, 1, 0, 2, 2, 2};
        for (int i = 0; i < 15; i++) begin
            bus(s[i]);
            chk("roles", {listener_lamp, talker_lamp}, e[i]);
        end
        chk("poll_valid", poll_valid, 8'h00);
        chk("status", status_byte, 8'h10);
        $display("t_addr done");
    endtask : t_addr

    task automatic t_local();
        remote_lvl = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("status", status_byte, 8'h18);
        chk("remote_lamp", remote_lamp, 8'h00);
        pulse(recall_display_cmd);
        chk("redisplay", redisplay, 8'h00);
        pulse(local_key);
        chk("front_srq", front_srq, 8'h01);
        lockout_lvl = 1'b1;
        pulse(local_key);
        chk("front_srq", front_srq, 8'h00);
        remote_lvl = 1'b1;
        lockout_lvl = 1'b0;
        pulse(recall_display_cmd);
        chk("redisplay", redisplay, 8'h01);
        chk("remote_lamp", remote_lamp, 8'h01);
        gsa_ctrl_model_inst.poll_ready(sb);
        chk("poll", sb, 8'h10);
        $display("t_local done");
    endtask : t_local

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge clk_sys);
        #1 chk("srq_oe_n", srq_oe_n, 8'h01);
        arst_n = 1'b1;
        @(posedge clk_sys);
        #1 t_poll();
        t_snap();
        t_fault();
        t_clear();
        t_addr();
        t_local();
        wrap_up();
    end
endmodule : gsa_status_addr_tb
